// File: pdh_params.svh
// Constants for the power-down and hold controller: opcodes, delays and clock divider.
`ifndef PDH_PARAMS_SVH
`define PDH_PARAMS_SVH
`define PDH_OP_POWER_DOWN 8'hB9
`define PDH_OP_RESUME     8'hAB
`define PDH_OP_WRITE_EN   8'h06
`define PDH_ENTRY_DELAY_NS 3000
`define PDH_EXIT_DELAY_NS  8000
`define PDH_CORE_PERIOD_NS 8
`define PDH_ENTRY_CYC ((`PDH_ENTRY_DELAY_NS) / (`PDH_CORE_PERIOD_NS))
`define PDH_EXIT_CYC  ((`PDH_EXIT_DELAY_NS) / (`PDH_CORE_PERIOD_NS))
`define PDH_SCK_DIV 4
`endif

// File: pdh_pkg.sv
// Types for the two ends of the power-down and hold link: power state for the device, shift state for the host.
package pdh_pkg;
  typedef enum logic [1:0] {
    PWR_STANDBY  = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_DOWN     = 2'b11,
    PWR_EXITING  = 2'b10
  } pwr_state_type;
  typedef enum logic [1:0] {
    HST_IDLE  = 2'b00,
    HST_SHIFT = 2'b01,
    HST_DONE  = 2'b11
  } host_state_type;
endpackage

// File: pdh_if.sv
// Serial link between the flash controller host and the device.
`timescale 1ns/1ps
interface pdh_if;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so_o;
  logic so_oe;
  modport device (input sck, input cs_n, input si, input hold_n, input wp_n,
                  output so_o, output so_oe);
  modport host (output sck, output cs_n, output si, output hold_n, output wp_n,
                input so_o, input so_oe);
endinterface

// File: pdh_sync.sv
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
module pdh_sync (
  input  wire logic i_clk,   // Destination clock.
  input  wire logic i_rst_n, // Asynchronous reset, active low.
  input  wire logic i_d,     // Level from another domain.
  output logic      o_q      // Synchronised level.
);
  logic meta_r;
  // First stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

// File: pdh_device.sv
// Device end: opcode decode on the link clock, power state on the core clock.
`timescale 1ns/1ps
`include "pdh_params.svh"
module pdh_device
  import pdh_pkg::*;
#(
  parameter int ENTRY_CYC = `PDH_ENTRY_CYC,
  parameter int EXIT_CYC  = `PDH_EXIT_CYC
) (
  input  wire logic I_CORE_CLK,   // Core clock, 125 MHz.
  input  wire logic I_RST_N,      // Asynchronous reset, active low.
  pdh_if.device     link,         // Serial pins.
  input  wire logic I_BUSY,       // Program or erase in progress.
  input  wire logic [7:0] I_TX,   // Byte the device shifts out.
  output logic      O_DEEP_PD,    // Deep power-down active.
  output logic      O_STANDBY,    // Idle low-power state.
  output logic      O_HELD,       // Hold mode active.
  output logic      O_WRITE_ENABLE_LATCH, // Write enable latch.
  output logic      O_ABORT       // One-cycle pulse: operation aborted by hold.
);
  // Link side state.
  logic [2:0]    bit_cnt_r;
  logic [7:0]    shift_r;
  logic          got_byte_r;
  logic [7:0]    opcode_r;
  logic          held_r;
  logic          cs_rise_tgl_r;
  logic [1:0]    cmd_r;       // 01 power-down, 10 resume, 11 write enable.
  logic          aligned_r;
  logic          hold_at_rise_r;
  logic [2:0]    out_idx_r;
  logic          oe_r;        // Output enabled from the first fall after the opcode.
  // Core side state.
  pwr_state_type pwr_r;
  logic [12:0]   cnt_r;
  logic          tgl_s;
  logic          tgl_d_r;
  logic          busy_at_cmd_r;
  logic          sck_act;

  // Hold takes effect only at the start of a clock low phase with chip select low.
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      held_r <= 1'b0;
    end else begin
      held_r <= ~link.hold_n;
    end
  end

  assign sck_act = ~held_r & ~link.cs_n;

  // Input bits are taken on the rising edge; counter restarts at chip select rise.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_r  <= 3'd0;
      got_byte_r <= 1'b0;
      shift_r    <= 8'h00;
      opcode_r   <= 8'h00;
    end else if (sck_act) begin
      shift_r   <= {shift_r[6:0], link.si};
      bit_cnt_r <= bit_cnt_r + 3'd1;
      if (bit_cnt_r == 3'd7 && !got_byte_r) begin
        got_byte_r <= 1'b1;
        opcode_r   <= {shift_r[6:0], link.si};
      end
    end
  end

  // Output bits are launched on the falling edge and float while held.
  // The enable also waits for a fall, so the pin never starts driving on a rise.
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      out_idx_r <= 3'd7;
      oe_r      <= 1'b0;
    end else if (sck_act && got_byte_r) begin
      oe_r <= 1'b1;
      if (oe_r) begin
        out_idx_r <= out_idx_r - 3'd1;
      end
    end
  end
  assign link.so_o  = I_TX[out_idx_r];
  assign link.so_oe = ~link.cs_n & ~held_r & oe_r & ~O_DEEP_PD;

  // At chip select rise capture the command outcome and flip the event toggle.
  always_ff @(posedge link.cs_n or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cmd_r          <= 2'b00;
      aligned_r      <= 1'b0;
      hold_at_rise_r <= 1'b0;
      cs_rise_tgl_r  <= 1'b0;
    end else begin
      aligned_r      <= got_byte_r && bit_cnt_r == 3'd0;
      hold_at_rise_r <= ~link.hold_n;
      cmd_r          <= !got_byte_r ? 2'b00 :
                        opcode_r == `PDH_OP_POWER_DOWN ? 2'b01 :
                        opcode_r == `PDH_OP_RESUME ? 2'b10 :
                        opcode_r == `PDH_OP_WRITE_EN ? 2'b11 : 2'b00;
      cs_rise_tgl_r  <= ~cs_rise_tgl_r;
    end
  end

  pdh_sync u_tgl_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_d     (cs_rise_tgl_r),
    .o_q     (tgl_s)
  );
  pdh_sync u_held_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_d     (held_r),
    .o_q     (O_HELD)
  );

  // Edge of the synchronised toggle marks a completed command frame.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tgl_d_r       <= 1'b0;
      busy_at_cmd_r <= 1'b0;
    end else begin
      tgl_d_r       <= tgl_s;
      busy_at_cmd_r <= I_BUSY;
    end
  end

  // Power state machine; reset lands in standby.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pwr_r <= PWR_STANDBY;
      cnt_r <= 13'd0;
    end else begin
      case (pwr_r)
        PWR_STANDBY: begin
          if (tgl_s != tgl_d_r && cmd_r == 2'b01 && aligned_r && !hold_at_rise_r
              && !I_BUSY && !busy_at_cmd_r) begin
            pwr_r <= PWR_ENTERING;
            cnt_r <= 13'(ENTRY_CYC - 1);
          end
        end
        PWR_ENTERING: begin
          if (cnt_r == 13'd0) begin
            pwr_r <= PWR_DOWN;
          end else begin
            cnt_r <= cnt_r - 13'd1;
          end
        end
        PWR_DOWN: begin
          if (tgl_s != tgl_d_r && cmd_r == 2'b10 && aligned_r
              && !hold_at_rise_r) begin
            pwr_r <= PWR_EXITING;
            cnt_r <= 13'(EXIT_CYC - 1);
          end
        end
        PWR_EXITING: begin
          if (cnt_r == 13'd0) begin
            pwr_r <= PWR_STANDBY;
          end else begin
            cnt_r <= cnt_r - 13'd1;
          end
        end
        default: begin
          pwr_r <= PWR_STANDBY;
        end
      endcase
    end
  end

  // Write enable latch: set by aligned write enable, cleared by hold abort.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WRITE_ENABLE_LATCH <= 1'b0;
      O_ABORT              <= 1'b0;
    end else begin
      O_ABORT <= 1'b0;
      if (tgl_s != tgl_d_r && pwr_r == PWR_STANDBY) begin
        if (hold_at_rise_r) begin
          O_WRITE_ENABLE_LATCH <= 1'b0;
          O_ABORT              <= 1'b1;
        end else if (cmd_r == 2'b11 && aligned_r) begin
          O_WRITE_ENABLE_LATCH <= 1'b1;
        end
      end
    end
  end

  // The busy input is never gated by hold, so self-timed work continues.
  assign O_DEEP_PD = (pwr_r == PWR_DOWN) || (pwr_r == PWR_EXITING);
  assign O_STANDBY = (pwr_r == PWR_STANDBY) && link.cs_n && !I_BUSY;
endmodule

// File: pdh_host.sv
// Host end: sends one command byte plus extra bits, clock made by a divider.
`timescale 1ns/1ps
`include "pdh_params.svh"
module pdh_host
  import pdh_pkg::*;
(
  input  wire logic I_CORE_CLK,    // Core clock.
  input  wire logic I_RST_N,       // Asynchronous reset, active low.
  pdh_if.host       link,          // Serial pins.
  input  wire logic I_START,       // Pulse: send a frame.
  input  wire logic [7:0] I_OPCODE, // Opcode to send.
  input  wire logic [3:0] I_EXTRA, // Extra bits after the opcode.
  input  wire logic [4:0] I_NBITS, // Total bits to clock (may be short or odd).
  input  wire logic I_HOLD,        // Request hold pin low.
  input  wire logic I_WP,          // Request write protect low.
  output logic      O_BUSY,        // Frame in progress.
  output logic      O_DONE,        // Pulse: frame finished.
  output logic [7:0] O_RX          // Bits sampled from the device.
);
  host_state_type st_r;
  logic [1:0]  div_r;
  logic        sck_r;
  logic [4:0]  left_r;
  logic [11:0] sh_r;
  logic        so_s;

  pdh_sync u_so_sync (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_d     (link.so_o),
    .o_q     (so_s)
  );

  // Divider clock; data launched one core cycle after rise, device output sampled at fall.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_r   <= HST_IDLE;
      div_r  <= 2'd0;
      sck_r  <= 1'b0;
      left_r <= 5'd0;
      sh_r   <= 12'h000;
      O_RX   <= 8'h00;
      O_DONE <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      case (st_r)
        HST_IDLE: begin
          if (I_START && I_NBITS != 5'd0) begin
            st_r   <= HST_SHIFT;
            sh_r   <= {I_OPCODE, I_EXTRA};
            left_r <= I_NBITS;
            div_r  <= 2'd0;
          end
        end
        HST_SHIFT: begin
          div_r <= div_r + 2'd1;
          if (div_r == 2'(`PDH_SCK_DIV / 2 - 1)) begin
            sck_r <= 1'b1;
          end else if (div_r == 2'(`PDH_SCK_DIV / 2)) begin
            // Next bit follows the rise by one core cycle, clear of the sampling edge.
            sh_r <= {sh_r[10:0], 1'b0};
          end else if (div_r == 2'(`PDH_SCK_DIV - 1)) begin
            sck_r  <= 1'b0;
            O_RX   <= {O_RX[6:0], so_s};
            left_r <= left_r - 5'd1;
            if (left_r == 5'd1) begin
              st_r <= HST_DONE;
            end
          end
        end
        HST_DONE: begin
          st_r   <= HST_IDLE;
          O_DONE <= 1'b1;
        end
        default: begin
          st_r <= HST_IDLE;
        end
      endcase
    end
  end

  assign link.sck    = sck_r;
  assign link.cs_n   = (st_r == HST_IDLE);
  assign link.si     = sh_r[11];
  assign link.hold_n = ~I_HOLD;
  assign link.wp_n   = ~I_WP;
  assign O_BUSY      = (st_r != HST_IDLE);
endmodule

// File: pdh_checker.sv
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/1ps
module pdh_checker (
  input wire logic I_CORE_CLK, // Core clock of both ends.
  input wire logic I_RST_N,    // Reset, active low.
  input wire logic sck,        // Link clock.
  input wire logic cs_n,       // Chip select, active low.
  input wire logic si,         // Host to device data.
  input wire logic hold_n,     // Hold, active low.
  input wire logic wp_n,       // Write protect, active low.
  input wire logic so_o,       // Device data.
  input wire logic so_oe       // Device drives its data pin.
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [4:0] rise_cnt_r;
  // Counts link clock rises within a frame so the opcode byte can be located.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) rise_cnt_r <= 5'h0;
    else if (cs_n) rise_cnt_r <= 5'h0;
    else if ($rose(sck) && rise_cnt_r != 5'h1f) rise_cnt_r <= rise_cnt_r + 5'h1;
  end
  sequence deselected_s;
    cs_n && $past(cs_n);
  endsequence
  sequence held_s;
    !cs_n && !hold_n && $past(!hold_n) && $fell(sck);
  endsequence
  cs_quiet_a: assert property (deselected_s |-> !so_oe)
    else $error("device output driven while deselected");
  sck_idle_a: assert property (deselected_s |-> !sck)
    else $error("link clock moves outside a frame");
  hold_float_a: assert property (held_s |=> !so_oe)
    else $error("device output driven while held");
  host_launch_a: assert property ((!cs_n && $past(!cs_n) && $changed(si))
                                  |-> (sck && $past(sck) && !$past(sck, 2)))
    else $error("host data changed outside the cycle after the link clock rose");
  dev_launch_a: assert property ((so_oe && $past(so_oe) && $changed(so_o)) |-> $fell(sck))
    else $error("device data changed off the falling link edge");
  oe_edge_a: assert property ($rose(so_oe) |-> $fell(sck))
    else $error("device output enabled off the falling link edge");
  opcode_quiet_a: assert property ((!cs_n && rise_cnt_r < 5'h8) |-> !so_oe)
    else $error("device drives output during the opcode byte");
  frame_len_a: assert property ($rose(cs_n) |-> rise_cnt_r <= 5'hc)
    else $error("frame longer than twelve link clocks");
endmodule

// File: flash_power_down_hold_ctrl_tb.sv
// Self-checking bench for the host and device ends joined by the link.
`timescale 1ns/1ps
module flash_power_down_hold_ctrl_tb;
  import pdh_pkg::*;
  localparam int ENT = 4;
  localparam int EXT = 4;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       busy = 1'b0;
  logic       start = 1'b0;
  logic       hold = 1'b0;
  logic       wp = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [4:0] nbits = 5'h08;
  logic       deep_pd, standby, held, we_latch, abort_p, host_busy, done;
  logic       abort_seen = 1'b0;
  int         n_fail = 0;
  int         num_checks = 0;
  pdh_if bus ();
  pdh_device #(.ENTRY_CYC(ENT), .EXIT_CYC(EXT)) pdh_device_inst (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .link(bus), .I_BUSY(busy), .I_TX(8'hA5),
    .O_DEEP_PD(deep_pd), .O_STANDBY(standby), .O_HELD(held), .O_WRITE_ENABLE_LATCH(we_latch),
    .O_ABORT(abort_p));
  pdh_host pdh_host_inst (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .link(bus), .I_START(start), .I_OPCODE(opcode),
    .I_EXTRA(4'hF), .I_NBITS(nbits), .I_HOLD(hold), .I_WP(wp), .O_BUSY(host_busy),
    .O_DONE(done), .O_RX());
  pdh_checker pdh_checker_inst (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .sck(bus.sck), .cs_n(bus.cs_n), .si(bus.si),
    .hold_n(bus.hold_n), .wp_n(bus.wp_n), .so_o(bus.so_o), .so_oe(bus.so_oe));
  // Core clock of 8 ns.
  always #4 clk = ~clk;
  // Catches the one-cycle abort pulse.
  always @(negedge clk) begin
    if (abort_p === 1'b1) abort_seen = 1'b1;
  end
  // Compares a seen value with the expected one.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Sends one frame and leaves time for the power state to settle.
  task automatic send(input logic [7:0] op, input logic [4:0] n);
    int k;
    @(posedge clk);
    opcode <= op;
    nbits <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) begin
      n_fail++;
      stop_test();
    end
    repeat (ENT + EXT + 12) @(negedge clk);
  endtask
  // Main sequence of commands and expectations.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wp <= 1'b1;
    repeat (2) @(negedge clk);
    check("standby", standby, 1);
    check("deep_pd", deep_pd, 0);
    send(8'h06, 5'd8);
    check("write_enable_latch", we_latch, 1);
    send(8'hB9, 5'd7);
    check("deep_pd", deep_pd, 0);
    send(8'hB9, 5'd12);
    check("deep_pd", deep_pd, 0);
    busy <= 1'b1;
    send(8'hB9, 5'd8);
    check("deep_pd", deep_pd, 0);
    check("standby", standby, 0);
    busy <= 1'b0;
    send(8'hB9, 5'd8);
    check("deep_pd", deep_pd, 1);
    send(8'hAB, 5'd7);
    check("deep_pd", deep_pd, 1);
    send(8'hAB, 5'd12);
    check("deep_pd", deep_pd, 1);
    send(8'hAB, 5'd8);
    check("deep_pd", deep_pd, 0);
    check("standby", standby, 1);
    hold <= 1'b1;
    wp <= 1'b0;
    repeat (10) @(negedge clk);
    check("held", held, 0);
    fork
      send(8'h06, 5'd8);
      begin
        repeat (20) @(negedge clk);
        check("held", held, 1);
      end
    join
    check("write_enable_latch", we_latch, 0);
    check("abort", abort_seen, 1);
    hold <= 1'b0;
    wp <= 1'b1;
    repeat (10) @(negedge clk);
    check("held", held, 0);
    send(8'h06, 5'd8);
    check("write_enable_latch", we_latch, 1);
    stop_test();
  end
endmodule
